//--- src/tcd_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the timing command decoder.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH

`define TCD_OFF_CMD 6'h00
`define TCD_OFF_ARG0 6'h04
`define TCD_OFF_ARG1 6'h08
`define TCD_OFF_ARG2 6'h0c
`define TCD_OFF_RESP 6'h10
`define TCD_OFF_STAT 6'h14
`define TCD_OFF_MASK 6'h18
`define TCD_OFF_CTRL 6'h1c

`define TCD_F_SUB 7:0
`define TCD_F_BYTE 15:8
`define TCD_F_QRY 16
`define TCD_F_VALID 31
`define TCD_F_RELOAD 0

`define TCD_MASK_PRI 0
`define TCD_MASK_SUP 2
`define TCD_MASK_AUTO 6
`define TCD_MASK0_USED 16'h0045
`define TCD_MASK0_RST 16'h0045

`define TCD_TC_RST 32'sh0000_01f4
`define TCD_DAMP_RST 32'sh0000_03e8
`define TCD_GAIN_RST 32'sh0000_03e8
`define TCD_VMIN_RST 32'sh0000_0000
`define TCD_VMAX_RST 32'sh0000_1388
`define TCD_THR_RST 32'sh0000_03e8
`define TCD_PPB_RST 32'sh0000_0032
`define TCD_INIT_DAC_RST 32'sh0000_09c4

`define TCD_JAM_MIN_NS 32'sh0000_0032
`define TCD_SLEW_MIN_PPB 32'sh0000_0005
`define TCD_ALIGN_NS 32'sh0000_0014

`define TCD_BCAST_MS 1000
`define TCD_CLK_KHZ 200000
`define TCD_BCAST_CYCLES (`TCD_BCAST_MS * `TCD_CLK_KHZ)

`endif

//--- src/tcd_pkg.sv
/*
 * Types of the timing command decoder: loop states and command codes.
 * Assumes nothing of its surroundings.
 */
package tcd_pkg;

  typedef enum logic [1:0] {
    TCD_ST_LOCK = 2'b00,
    TCD_ST_HOLD = 2'b01,
    TCD_ST_RECOV = 2'b11,
    TCD_ST_OFF = 2'b10
  } tcd_disc_t;

  typedef enum logic [7:0] {
    TCD_SUB_DISC = 8'ha3,
    TCD_SUB_MASK = 8'ha5,
    TCD_SUB_SURV = 8'ha6,
    TCD_SUB_REF = 8'ha7,
    TCD_SUB_PARAM = 8'ha8
  } tcd_sub_t;

  typedef enum logic [7:0] {
    TCD_DC_JAM = 8'h00,
    TCD_DC_RECOVER = 8'h01,
    TCD_DC_HOLD_IN = 8'h02,
    TCD_DC_HOLD_OUT = 8'h03,
    TCD_DC_OFF = 8'h04,
    TCD_DC_ON = 8'h05
  } tcd_dcmd_t;

  typedef enum logic [7:0] {
    TCD_SV_RESTART = 8'h00,
    TCD_SV_STORE = 8'h01,
    TCD_SV_ERASE = 8'h02
  } tcd_surv_t;

  typedef enum logic [7:0] {
    TCD_REF_SAT = 8'h00,
    TCD_REF_EXT = 8'h01
  } tcd_ref_t;

endpackage

//--- src/tcd_sec_tick.sv
/*
 * Divider that gives a one-cycle tick every PERIOD clock cycles.
 * Assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/10ps

module tcd_sec_tick #(
  parameter int unsigned PERIOD = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  output logic o_tick
);

  localparam int W = ($clog2(PERIOD) < 1) ? 1 : $clog2(PERIOD);

  logic [W-1:0] cnt_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q == W'(PERIOD - 1)) begin
      cnt_q <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule

//--- src/tcd_clamp.sv
/*
 * Combinational signed limiter: holds a value between two bounds.
 * Assumes the lower bound is not above the upper bound.
 */
`timescale 1ns/10ps

module tcd_clamp (
  input wire logic signed [31:0] i_val,
  input wire logic signed [31:0] i_lo,
  input wire logic signed [31:0] i_hi,
  output logic signed [31:0] o_val
);

  always_comb begin
    if (i_val < i_lo) begin
      o_val = i_lo;
    end else if (i_val > i_hi) begin
      o_val = i_hi;
    end else begin
      o_val = i_val;
    end
  end

endmodule

//--- src/tcd_top.sv
/*
 * Host command decoder of a disciplined timing module: takes command
 * frames over an Avalon-MM slave, drives the disciplining loop state,
 * broadcast gating, survey strobes, reference choice and loop settings.
 * Assumes the offset and loop DAC inputs come from logic on i_core_clk.
 */
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "tcd_map.svh"

// Overview of operation
// - Disciplining command answered with an echo.
// - Disciplining codes one to five drive states.
// - Mask command sets masks or returns them.
// - Mask bit one enables, zero suppresses broadcast.
// - Bits 0, 2, 6 gate primary, supplemental, auto.
// - Survey codes restart, store, erase; then report.
// - Reference zero satellite, one external; report.
// - Type-only parameter packet is a query; always answer.
// - Type zero sets loop time constant, damping.
// - Type one sets gain; DAC kept within bounds.
// - Recovery removes offset by stepping or slewing.
// - Recovery offset above threshold triggers jam sync.
// - Active jam threshold never below 50 ns.
// - Threshold at or below zero stops auto jams.
// - Recovery slew limited, limit at least 5 ppb.
// - Type three initial DAC loaded on a reload write.
// - Enabled primary report broadcast every second.
module tcd_top #(
  parameter int unsigned BCAST_CYCLES = `TCD_BCAST_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic signed [31:0] i_pps_offset_ns,
  input wire logic signed [31:0] i_loop_dac_mv,
  output logic [1:0] o_disc_state,
  output logic o_ref_external,
  output logic o_jam_sync,
  output logic signed [31:0] o_dac_mv,
  output logic signed [31:0] o_slew_ppb,
  output logic signed [31:0] o_time_const_s,
  output logic signed [31:0] o_damping_milli,
  output logic signed [31:0] o_osc_gain,
  output logic o_survey_restart,
  output logic o_pos_store,
  output logic o_pos_erase,
  output logic o_bcast_primary,
  output logic o_bcast_supp,
  output logic o_bcast_auto
);

  logic ack_q;
  logic rd_take;
  logic wr_take;
  logic cmd_go;
  logic reload;
  logic [7:0] sub;
  logic [7:0] cb;
  logic qry;
  logic acc;
  logic rsp;
  logic go_disc;
  logic go_mask;
  logic go_surv;
  logic go_ref;
  logic go_set;
  logic tick;
  logic man_jam;
  logic auto_jam;
  logic [31:0] rdata_d;
  logic [31:0] resp_q;
  logic pend_q;
  logic [7:0] pend_sub_q;
  logic [7:0] pend_cb_q;
  logic [31:0] args_q [3];
  logic signed [31:0] rb [3];
  logic [15:0] mask0_q;
  tcd_pkg::tcd_disc_t state_q;
  logic signed [31:0] vmin_q;
  logic signed [31:0] vmax_q;
  logic signed [31:0] thr_q;
  logic signed [31:0] ppb_q;
  logic signed [31:0] init_q;
  logic signed [31:0] off_abs;
  logic signed [31:0] dac_src;
  logic signed [31:0] dac_lim;
  logic signed [31:0] slew_lim;
  logic signed [31:0] neg_off;
  logic signed [31:0] neg_ppb;

  function automatic logic hit(input logic [5:0] addr,
                               input logic [5:0] off);
    hit = (addr[5:2] == off[5:2]);
  endfunction

  function automatic logic signed [31:0] abs32(
      input logic signed [31:0] v);
    abs32 = (v < 0) ? -v : v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                       input logic [31:0] n,
                                       input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // Every access waits exactly one cycle, then is taken on the next edge.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign rd_take = ack_q & i_avs_read;
  assign wr_take = ack_q & i_avs_write;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(i_avs_address, `TCD_OFF_ARG0)) begin
      rdata_d = args_q[0];
    end else if (hit(i_avs_address, `TCD_OFF_ARG1)) begin
      rdata_d = args_q[1];
    end else if (hit(i_avs_address, `TCD_OFF_ARG2)) begin
      rdata_d = args_q[2];
    end else if (hit(i_avs_address, `TCD_OFF_RESP)) begin
      rdata_d = resp_q;
    end else if (hit(i_avs_address, `TCD_OFF_STAT)) begin
      rdata_d = {28'h000_0000, resp_q[`TCD_F_VALID], o_ref_external,
                 state_q};
    end else if (hit(i_avs_address, `TCD_OFF_MASK)) begin
      rdata_d = {16'h0000, mask0_q};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & ~ack_q) begin
      o_avs_readdata <= rdata_d;
    end
  end

  assign sub = i_avs_writedata[`TCD_F_SUB];
  assign cb = i_avs_writedata[`TCD_F_BYTE];
  assign qry = i_avs_writedata[`TCD_F_QRY];
  assign cmd_go = wr_take & hit(i_avs_address, `TCD_OFF_CMD)
                  & (&i_avs_byteenable[2:0]);
  assign reload = wr_take & hit(i_avs_address, `TCD_OFF_CTRL)
                  & i_avs_byteenable[0] & i_avs_writedata[`TCD_F_RELOAD];

  // Codes outside each command's list leave acc low and change nothing.
  always_comb begin
    acc = 1'b0;
    rsp = 1'b0;
    case (sub)
      tcd_pkg::TCD_SUB_DISC: begin
        acc = (cb <= tcd_pkg::TCD_DC_ON);
        rsp = acc;
      end
      tcd_pkg::TCD_SUB_MASK: begin
        acc = 1'b1;
        rsp = qry;
      end
      tcd_pkg::TCD_SUB_SURV: begin
        acc = (cb <= tcd_pkg::TCD_SV_ERASE);
        rsp = acc;
      end
      tcd_pkg::TCD_SUB_REF: begin
        acc = (cb <= tcd_pkg::TCD_REF_EXT);
        rsp = acc;
      end
      tcd_pkg::TCD_SUB_PARAM: begin
        acc = (cb <= 8'h03) && (qry || cb != 8'h01
              || $signed(args_q[1]) <= $signed(args_q[2]));
        rsp = acc;
      end
      default: begin
        acc = 1'b0;
        rsp = 1'b0;
      end
    endcase
  end

  assign go_disc = cmd_go & acc & (sub == tcd_pkg::TCD_SUB_DISC);
  assign go_mask = cmd_go & acc & (sub == tcd_pkg::TCD_SUB_MASK) & ~qry;
  assign go_surv = cmd_go & acc & (sub == tcd_pkg::TCD_SUB_SURV);
  assign go_ref = cmd_go & acc & (sub == tcd_pkg::TCD_SUB_REF);
  assign go_set = cmd_go & acc & (sub == tcd_pkg::TCD_SUB_PARAM) & ~qry;
  assign off_abs = abs32(i_pps_offset_ns);

  // Commands win over the automatic end of recovery.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= tcd_pkg::TCD_ST_LOCK;
    end else if (go_disc) begin
      if (cb == tcd_pkg::TCD_DC_RECOVER && state_q != tcd_pkg::TCD_ST_OFF)
      begin
        state_q <= tcd_pkg::TCD_ST_RECOV;
      end else if (cb == tcd_pkg::TCD_DC_HOLD_IN
                   && state_q != tcd_pkg::TCD_ST_OFF) begin
        state_q <= tcd_pkg::TCD_ST_HOLD;
      end else if (cb == tcd_pkg::TCD_DC_HOLD_OUT
                   && state_q == tcd_pkg::TCD_ST_HOLD) begin
        state_q <= tcd_pkg::TCD_ST_RECOV;
      end else if (cb == tcd_pkg::TCD_DC_OFF) begin
        state_q <= tcd_pkg::TCD_ST_OFF;
      end else if (cb == tcd_pkg::TCD_DC_ON
                   && state_q == tcd_pkg::TCD_ST_OFF) begin
        state_q <= tcd_pkg::TCD_ST_LOCK;
      end
    end else begin
      unique case (state_q)
        tcd_pkg::TCD_ST_RECOV: begin
          if (off_abs <= `TCD_ALIGN_NS) begin
            state_q <= tcd_pkg::TCD_ST_LOCK;
          end
        end
        tcd_pkg::TCD_ST_LOCK, tcd_pkg::TCD_ST_HOLD,
        tcd_pkg::TCD_ST_OFF: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  assign o_disc_state = state_q;

  // A manual jam is honoured whatever the threshold holds.
  assign man_jam = go_disc & (cb == tcd_pkg::TCD_DC_JAM);
  assign auto_jam = (state_q == tcd_pkg::TCD_ST_RECOV) & (thr_q > 0)
                    & (off_abs > thr_q) & ~o_jam_sync;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_jam_sync <= 1'b0;
    end else begin
      o_jam_sync <= man_jam | auto_jam;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_survey_restart <= 1'b0;
      o_pos_store <= 1'b0;
      o_pos_erase <= 1'b0;
    end else begin
      o_survey_restart <= go_surv & (cb == tcd_pkg::TCD_SV_RESTART);
      o_pos_store <= go_surv & (cb == tcd_pkg::TCD_SV_STORE);
      o_pos_erase <= go_surv & (cb == tcd_pkg::TCD_SV_ERASE);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_ref_external <= 1'b0;
    end else if (go_ref) begin
      o_ref_external <= (cb == tcd_pkg::TCD_REF_EXT);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mask0_q <= `TCD_MASK0_RST;
    end else if (go_mask) begin
      mask0_q <= args_q[0][15:0] & `TCD_MASK0_USED;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_time_const_s <= `TCD_TC_RST;
      o_damping_milli <= `TCD_DAMP_RST;
      o_osc_gain <= `TCD_GAIN_RST;
      vmin_q <= `TCD_VMIN_RST;
      vmax_q <= `TCD_VMAX_RST;
      thr_q <= `TCD_THR_RST;
      ppb_q <= `TCD_PPB_RST;
      init_q <= `TCD_INIT_DAC_RST;
    end else if (go_set) begin
      unique case (cb[1:0])
        2'h0: begin
          o_time_const_s <= $signed(args_q[0]);
          o_damping_milli <= $signed(args_q[1]);
        end
        2'h1: begin
          o_osc_gain <= $signed(args_q[0]);
          vmin_q <= $signed(args_q[1]);
          vmax_q <= $signed(args_q[2]);
        end
        2'h2: begin
          if ($signed(args_q[0]) <= 0 ||
              $signed(args_q[0]) >= `TCD_JAM_MIN_NS) begin
            thr_q <= $signed(args_q[0]);
          end else begin
            thr_q <= `TCD_JAM_MIN_NS;
          end
          if ($signed(args_q[1]) < `TCD_SLEW_MIN_PPB) begin
            ppb_q <= `TCD_SLEW_MIN_PPB;
          end else begin
            ppb_q <= $signed(args_q[1]);
          end
        end
        2'h3: begin
          init_q <= $signed(args_q[0]);
        end
      endcase
    end
  end

  // The DAC follows the loop only while disciplining and stays bounded.
  always_comb begin
    if (reload) begin
      dac_src = init_q;
    end else if (state_q == tcd_pkg::TCD_ST_LOCK
                 || state_q == tcd_pkg::TCD_ST_RECOV) begin
      dac_src = i_loop_dac_mv;
    end else begin
      dac_src = o_dac_mv;
    end
  end

  tcd_clamp u_dac_clamp (
    .i_val(dac_src),
    .i_lo(vmin_q),
    .i_hi(vmax_q),
    .o_val(dac_lim)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dac_mv <= `TCD_INIT_DAC_RST;
    end else begin
      o_dac_mv <= dac_lim;
    end
  end

  assign neg_off = -i_pps_offset_ns;
  assign neg_ppb = -ppb_q;

  tcd_clamp u_slew_clamp (
    .i_val(neg_off),
    .i_lo(neg_ppb),
    .i_hi(ppb_q),
    .o_val(slew_lim)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_slew_ppb <= 32'sh0000_0000;
    end else if (state_q == tcd_pkg::TCD_ST_RECOV) begin
      o_slew_ppb <= slew_lim;
    end else begin
      o_slew_ppb <= 32'sh0000_0000;
    end
  end

  tcd_sec_tick #(
    .PERIOD(BCAST_CYCLES)
  ) u_sec_tick (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_bcast_primary <= 1'b0;
      o_bcast_supp <= 1'b0;
      o_bcast_auto <= 1'b0;
    end else begin
      o_bcast_primary <= tick & mask0_q[`TCD_MASK_PRI];
      o_bcast_supp <= tick & mask0_q[`TCD_MASK_SUP];
      o_bcast_auto <= tick & mask0_q[`TCD_MASK_AUTO];
    end
  end

  // The answer is built one cycle after the command, from stored values.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend_q <= 1'b0;
      pend_sub_q <= 8'h00;
      pend_cb_q <= 8'h00;
    end else begin
      pend_q <= cmd_go & acc & rsp;
      pend_sub_q <= sub;
      pend_cb_q <= cb;
    end
  end

  always_comb begin
    rb[0] = 32'sh0000_0000;
    rb[1] = 32'sh0000_0000;
    rb[2] = 32'sh0000_0000;
    unique case (pend_cb_q[1:0])
      2'h0: begin
        rb[0] = o_time_const_s;
        rb[1] = o_damping_milli;
      end
      2'h1: begin
        rb[0] = o_osc_gain;
        rb[1] = vmin_q;
        rb[2] = vmax_q;
      end
      2'h2: begin
        rb[0] = thr_q;
        rb[1] = ppb_q;
      end
      2'h3: begin
        rb[0] = init_q;
      end
    endcase
  end

  // A new answer wins over a read that clears the valid flag.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      resp_q <= 32'h0000_0000;
    end else if (pend_q) begin
      resp_q <= {1'b1, 15'h0000, pend_cb_q, pend_sub_q};
    end else if (rd_take && hit(i_avs_address, `TCD_OFF_RESP)) begin
      resp_q[`TCD_F_VALID] <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < 3; i++) begin
        args_q[i] <= 32'h0000_0000;
      end
    end else if (pend_q && pend_sub_q == tcd_pkg::TCD_SUB_PARAM) begin
      for (int i = 0; i < 3; i++) begin
        args_q[i] <= rb[i];
      end
    end else if (pend_q && pend_sub_q == tcd_pkg::TCD_SUB_MASK) begin
      args_q[0] <= {16'h0000, mask0_q};
    end else if (wr_take) begin
      for (int i = 0; i < 3; i++) begin
        if (hit(i_avs_address, `TCD_OFF_ARG0 + 6'(4 * i))) begin
          args_q[i] <= merge(args_q[i], i_avs_writedata, i_avs_byteenable);
        end
      end
    end
  end

  default clocking cb_chk @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  chk_disc_echo: assert property (
    go_disc |=> ##1 resp_q[`TCD_F_VALID] && resp_q[7:0] == 8'ha3
      && resp_q[15:8] == $past(cb, 2))
    else $error("disciplining answer does not echo the command");
  chk_recov_enter: assert property (
    go_disc && cb == 8'h01 && state_q != tcd_pkg::TCD_ST_OFF
      |=> state_q == tcd_pkg::TCD_ST_RECOV)
    else $error("recovery command did not enter recovery");
  chk_mask_gate: assert property (
    tick && !mask0_q[`TCD_MASK_PRI] |=> !o_bcast_primary)
    else $error("primary broadcast sent while masked");
  chk_ref_select: assert property (
    go_ref |=> o_ref_external == $past(cb[0]))
    else $error("reference choice not applied");
  chk_dac_bounds: assert property (
    1'b1 |=> o_dac_mv >= $past(vmin_q) && o_dac_mv <= $past(vmax_q))
    else $error("DAC value outside its bounds");
  chk_auto_jam: assert property (
    auto_jam && !man_jam |=> o_jam_sync ##1 o_jam_sync == $past(man_jam))
    else $error("automatic jam sync not issued as one pulse");
  chk_thr_floor: assert property (
    thr_q <= 0 || thr_q >= `TCD_JAM_MIN_NS)
    else $error("active jam threshold below floor");
  chk_jam_off: assert property (
    thr_q <= 0 && !man_jam |=> !o_jam_sync)
    else $error("jam sync issued while disabled");
  chk_slew_limit: assert property (
    1'b1 |=> ppb_q >= `TCD_SLEW_MIN_PPB
      && abs32(o_slew_ppb) <= $past(ppb_q))
    else $error("recovery slew beyond its limit");
  chk_bad_ignored: assert property (
    cmd_go && !acc |=> $stable(mask0_q) && $stable(o_ref_external)
      && $stable(resp_q) && $stable(o_time_const_s)
      && o_jam_sync == $past(auto_jam))
    else $error("unknown command changed state");

  cov_auto_jam: cover property (auto_jam ##1 o_jam_sync);
  cov_param_query: cover property (
    cmd_go && acc && qry && sub == 8'ha8 ##2 resp_q[`TCD_F_VALID]);
  cov_bcast: cover property (o_bcast_primary);

endmodule

//--- dv/tcd_host.sv
/*
 * Host model: an Avalon-MM master that issues one word access at a time.
 * Assumes a slave on the same clock that drops waitrequest to answer.
 */
`timescale 1ns/10ps

module tcd_host (
  input wire logic i_core_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_wait,
  output logic [5:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be
);
  bit tmo = 1'b0;

  initial begin
    o_addr = 6'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h0;
    o_be = 4'h0;
  end

  // Call just after a rising edge; it returns one edge after the release,
  // so back-to-back calls never drive a strobe twice in one time step.
  task automatic xfer(input logic rd, input logic [5:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    o_addr <= a;
    o_wdata <= d;
    o_be <= be;
    o_rd <= rd;
    o_wr <= !rd;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_wait !== 1'b0 && n < 50);
    q = i_rdata;
    if (i_wait !== 1'b0)
      tmo = 1'b1;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask
endmodule

//--- dv/tcd_top_test.sv
/*
 * Self-checking bench of the timing command decoder.
 * Assumes the host model drives the bus and this bench drives the loop.
 */
`timescale 1ns/10ps
`include "tcd_map.svh"

module tcd_top_test;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [5:0] addr;
  logic rd, wrt, waitreq, o_jam_sync, o_ref_external;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic signed [31:0] offs = 32'h0;
  logic signed [31:0] dac_in = 32'h9c4;
  logic [1:0] o_disc_state;
  logic signed [31:0] o_dac_mv, o_slew_ppb, o_time_const_s;
  logic signed [31:0] o_damping_milli, o_osc_gain;
  wire [6:0] pulses;
  int pc [7] = '{default: 0};
  int base [7];
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] dc [8] = '{8'h02, 8'h03, 8'h04, 8'h01, 8'h05, 8'h01, 8'h06,
    8'h00};
  logic [1:0] st [8] = '{2'h1, 2'h3, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h3};
  logic [15:0] mk [5] = '{16'hffff, 16'h0001, 16'h0004, 16'h0040, 16'h0000};

  initial begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  // Pulses are counted on the falling edge, where they are settled.
  always @(negedge i_core_clk) begin
    for (int k = 0; k < 7; k++)
      pc[k] += pulses[k];
  end

  tcd_host host (.i_core_clk(i_core_clk), .i_rdata(rdata), .i_wait(waitreq),
    .o_addr(addr), .o_rd(rd), .o_wr(wrt), .o_wdata(wdata), .o_be(be));

  tcd_top #(.BCAST_CYCLES(50)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wrt),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_pps_offset_ns(offs),
    .i_loop_dac_mv(dac_in), .o_disc_state(o_disc_state),
    .o_ref_external(o_ref_external), .o_jam_sync(o_jam_sync),
    .o_dac_mv(o_dac_mv), .o_slew_ppb(o_slew_ppb),
    .o_time_const_s(o_time_const_s), .o_damping_milli(o_damping_milli),
    .o_osc_gain(o_osc_gain), .o_survey_restart(pulses[1]),
    .o_pos_store(pulses[2]), .o_pos_erase(pulses[3]),
    .o_bcast_primary(pulses[4]), .o_bcast_supp(pulses[5]),
    .o_bcast_auto(pulses[6]));
  assign pulses[0] = o_jam_sync;

  task automatic test_done();
    if (host.tmo)
      error_cnt++;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
      input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk_pulse(input string w, input int k, input int e);
    compares++;
    if (pc[k] - base[k] != e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", w, e,
        pc[k] - base[k]);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b0, a, d, 4'hf, q);
    if (host.tmo)
      test_done();
  endtask

  task automatic rchk(input string w, input logic [5:0] a,
      input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b1, a, 32'h0, 4'hf, q);
    if (host.tmo)
      test_done();
    chk(w, e, q);
  endtask

  task automatic cmd(input logic [7:0] s, input logic [7:0] c,
      input logic q = 1'b0);
    wr(`TCD_OFF_CMD, {15'h0, q, c, s});
  endtask

  function automatic logic [31:0] ans(input logic [7:0] s,
      input logic [7:0] c);
    return {16'h8000, c, s};
  endfunction

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  initial begin
    wait_n(10);
    chk("reset dac", 32'h9c4, o_dac_mv);
    i_rst <= 1'b0;
    wait_n(1);
    rchk("status", `TCD_OFF_STAT, 32'h0);
    rchk("unmapped", 6'h20, 32'h0);
    offs <= 32'h1e;
    for (int i = 0; i < 8; i++) begin
      base = pc;
      cmd(8'ha3, dc[i]);
      chk("state", st[i], o_disc_state);
      rchk("stat", `TCD_OFF_STAT, {28'h0, dc[i] < 8'h06, 1'b0, st[i]});
      if (dc[i] < 8'h06)
        rchk("echo", `TCD_OFF_RESP, ans(8'ha3, dc[i]));
    end
    chk_pulse("manual jam", 0, 1);
    chk("slew", 32'hffff_ffe2, o_slew_ppb);
    $display("test disciplining done");
    cmd(8'ha5, 8'h00, 1'b1);
    rchk("mask query", `TCD_OFF_ARG0, 32'h45);
    foreach (mk[i]) begin
      wr(`TCD_OFF_ARG0, {16'h0, mk[i]});
      cmd(8'ha5, 8'h00);
      rchk("mask", `TCD_OFF_MASK, {16'h0, mk[i] & 16'h0045});
      base = pc;
      wait_n(200);
      chk_pulse("primary", 4, mk[i][0] ? 4 : 0);
      chk_pulse("supplemental", 5, mk[i][2] ? 4 : 0);
      chk_pulse("automatic", 6, mk[i][6] ? 4 : 0);
    end
    $display("test mask done");
    for (int i = 0; i < 3; i++) begin
      base = pc;
      cmd(8'ha6, i[7:0]);
      rchk("survey echo", `TCD_OFF_RESP, ans(8'ha6, i[7:0]));
      chk_pulse("restart", 1, i == 0);
      chk_pulse("store", 2, i == 1);
      chk_pulse("erase", 3, i == 2);
    end
    // The loop is locked first; the external reference choice does not depend on the loop state.
    offs <= 32'h0;
    wait_n(4);
    chk("locked", 2'h0, o_disc_state);
    cmd(8'ha7, 8'h01);
    chk("ref ext", 1'b1, o_ref_external);
    rchk("ref echo", `TCD_OFF_RESP, ans(8'ha7, 8'h01));
    cmd(8'ha7, 8'h02);
    chk("ref kept", 1'b1, o_ref_external);
    cmd(8'ha7, 8'h00);
    chk("ref sat", 1'b0, o_ref_external);
    $display("test survey and reference done");
    wr(`TCD_OFF_ARG0, 32'h64);
    wr(`TCD_OFF_ARG1, 32'h2bc);
    cmd(8'ha8, 8'h00);
    chk("time const", 32'h64, o_time_const_s);
    chk("damping", 32'h2bc, o_damping_milli);
    rchk("param echo", `TCD_OFF_RESP, ans(8'ha8, 8'h00));
    wr(`TCD_OFF_ARG0, 32'h0);
    cmd(8'ha8, 8'h00, 1'b1);
    rchk("param query", `TCD_OFF_ARG0, 32'h64);
    wr(`TCD_OFF_ARG0, 32'h7d0);
    wr(`TCD_OFF_ARG1, 32'h3e8);
    wr(`TCD_OFF_ARG2, 32'hbb8);
    cmd(8'ha8, 8'h01);
    chk("gain", 32'h7d0, o_osc_gain);
    dac_in <= 32'hfa0;
    wait_n(3);
    chk("dac high", 32'hbb8, o_dac_mv);
    dac_in <= 32'h1f4;
    wait_n(3);
    chk("dac low", 32'h3e8, o_dac_mv);
    $display("test loop settings done");
    wr(`TCD_OFF_ARG0, 32'ha);
    wr(`TCD_OFF_ARG1, 32'h2);
    cmd(8'ha8, 8'h02);
    cmd(8'ha8, 8'h02, 1'b1);
    rchk("threshold", `TCD_OFF_ARG0, 32'h32);
    rchk("max ppb", `TCD_OFF_ARG1, 32'h5);
    offs <= 32'h1e;
    cmd(8'ha3, 8'h01);
    wait_n(2);
    chk("slew limit", 32'hffff_fffb, o_slew_ppb);
    base = pc;
    offs <= 32'h64;
    wait_n(20);
    chk("auto jam", 1'b1, pc[0] - base[0] >= 9);
    // A zero threshold stops automatic jams; a manual jam still passes.
    wr(`TCD_OFF_ARG0, 32'h0);
    cmd(8'ha8, 8'h02);
    base = pc;
    wait_n(20);
    chk_pulse("no auto jam", 0, 0);
    cmd(8'ha3, 8'h00);
    chk_pulse("manual jam", 0, 1);
    cmd(8'ha3, 8'h02);
    wr(`TCD_OFF_ARG0, 32'h5dc);
    cmd(8'ha8, 8'h03);
    wr(`TCD_OFF_CTRL, 32'h1);
    chk("initial dac", 32'h5dc, o_dac_mv);
    $display("test recovery done");
    test_done();
  end
endmodule
